// ---- design/cache_lock_pkg.sv ----
// Constants, bit positions and types shared by the cache lock control files
package cache_lock_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Word layout; bit positions are big-endian, bit 0 is the word's MSB
    localparam int WORD_W   = 32;
    localparam int WORD_MSB = WORD_W - 1;

    // impl_config_a bits
    localparam int INSTR_CACHE_ENABLE_POS     = 16;
    localparam int DATA_CACHE_ENABLE_POS      = 17;
    localparam int INSTR_WHOLE_LOCK_POS       = 18;
    localparam int DATA_WHOLE_LOCK_POS        = 19;
    localparam int INSTR_FLASH_INVALIDATE_POS = 20;
    localparam int DATA_FLASH_INVALIDATE_POS  = 21;

    // impl_config_b fields, first and last bit of each
    localparam int INSTR_WAY_LOCK_FIRST = 16;
    localparam int INSTR_WAY_LOCK_LAST  = 18;
    localparam int DATA_WAY_LOCK_FIRST  = 24;
    localparam int DATA_WAY_LOCK_LAST   = 26;
    localparam int WAY_COUNT_W          = DATA_WAY_LOCK_LAST
                                          - DATA_WAY_LOCK_FIRST + 1;

    // machine_state bits
    localparam int EXT_IRQ_ENABLE_POS       = 16;
    localparam int MACHINE_CHECK_ENABLE_POS = 19;
    localparam int INSTR_TRANSLATE_EN_POS   = 26;
    localparam int DATA_TRANSLATE_EN_POS    = 27;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [WORD_W-1:0] IMPL_CONFIG_A_RESET = 32'h0000_0000;
    localparam logic [WORD_W-1:0] IMPL_CONFIG_B_RESET = 32'h0000_0000;
    localparam logic [WORD_W-1:0] MACHINE_STATE_RESET = 32'h0000_0000;

    // Default geometry
    localparam int DEF_WAYS   = 8;
    localparam int DEF_ADDR_W = 32;

    ////////////////////////////////////////////////////////////////////////
    // Register select codes on the special-purpose register port
    typedef enum logic [1:0]
    {
        SEL_IMPL_CONFIG_A = 2'b00,
        SEL_IMPL_CONFIG_B = 2'b01,
        SEL_MACHINE_STATE = 2'b10,
        SEL_UNMAPPED      = 2'b11
    } spr_sel_type;

    // Big-endian bit number to vector index
    function automatic int lsb_index(input int be_pos);
        return WORD_MSB - be_pos;
    endfunction

endpackage

// ---- design/cache_lock_if.sv ----
// Carrier between the lock control registers and one cache's lock unit
`timescale 1ns/100ps
interface cache_lock_if
#(
    parameter int WAYS   = cache_lock_pkg::DEF_WAYS,
    parameter int ADDR_W = cache_lock_pkg::DEF_ADDR_W
);
    localparam int WAY_W = $clog2(WAYS);

    // Control from registers
    logic                                   enable;
    logic                                   whole_lock;
    logic [cache_lock_pkg::WAY_COUNT_W-1:0] way_count;
    logic                                   flash_req;
    // Requests from the cache
    logic                                   miss_req;
    logic [WAY_W-1:0]                       victim_hint;
    logic                                   binv_req;
    logic [ADDR_W-1:0]                      binv_addr;
    // Answers to the cache
    logic [WAYS-1:0]                        lock_mask;
    logic                                   fill_valid;
    logic                                   fill_alloc;
    logic [WAY_W-1:0]                       fill_way;
    logic                                   binv_valid;
    logic [ADDR_W-1:0]                      binv_addr_out;
    logic                                   flash_inval;

    modport ctrl
    (
        output enable, whole_lock, way_count, flash_req,
        output miss_req, victim_hint, binv_req, binv_addr,
        input  lock_mask, fill_valid, fill_alloc, fill_way,
        input  binv_valid, binv_addr_out, flash_inval
    );

    modport unit
    (
        input  enable, whole_lock, way_count, flash_req,
        input  miss_req, victim_hint, binv_req, binv_addr,
        output lock_mask, fill_valid, fill_alloc, fill_way,
        output binv_valid, binv_addr_out, flash_inval
    );
endinterface

// ---- design/way_lock_unit.sv ----
// Lock mask, victim choice and invalidation for one cache
`timescale 1ns/100ps
module way_lock_unit
#(
    parameter int WAYS   = cache_lock_pkg::DEF_WAYS,
    parameter int ADDR_W = cache_lock_pkg::DEF_ADDR_W
)
(
    // Clock, reset and clock enable
    input wire logic   clk_sys,
    input wire logic   rstn,
    input wire logic   ce,
    // Register side and cache side
    cache_lock_if.unit lk
);
    localparam int WAY_W = $clog2(WAYS);

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // The count field reaches seven, and one way must stay free
    if (WAYS < (1 << cache_lock_pkg::WAY_COUNT_W) || WAYS != (1 << WAY_W))
    begin : g_bad_ways
        $error("way_lock_unit: WAYS must be a power of two of at least 8");
    end

    ////////////////////////////////////////////////////////////////////////
    logic [WAYS-1:0]   mask_d;
    logic [WAYS-1:0]   mask_q;
    logic              fill_valid_d;
    logic              fill_valid_q;
    logic              fill_alloc_d;
    logic              fill_alloc_q;
    logic [WAY_W-1:0]  fill_way_d;
    logic [WAY_W-1:0]  fill_way_q;
    logic              binv_valid_d;
    logic              binv_valid_q;
    logic [ADDR_W-1:0] binv_addr_d;
    logic [ADDR_W-1:0] binv_addr_q;
    logic              flash_d;
    logic              flash_q;

    // Locked ways always run from way 0 upward
    for (genvar i = 0; i < WAYS; i++)
    begin : g_mask
        assign mask_d[i] = lk.enable
                           && (lk.whole_lock                     // see R1, R15
                               || (i < int'(lk.way_count)));     // see R4, R14
    end

    always_comb
    begin
        fill_valid_d = lk.miss_req;
        // Whole lock or disabled cache: miss goes through uncached
        fill_alloc_d = lk.miss_req && lk.enable && !lk.whole_lock; // see R17
        // Ways are contiguous, so the count is the lowest free way
        if (mask_d[lk.victim_hint])
            fill_way_d = WAY_W'(lk.way_count);                   // see R18
        else
            fill_way_d = lk.victim_hint;
        // Block invalidation ignores every lock
        binv_valid_d = lk.binv_req;                              // see R10, R11
        binv_addr_d  = lk.binv_req ? lk.binv_addr : binv_addr_q;
        flash_d      = lk.flash_req;                             // see R9
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            mask_q       <= '0;
            fill_valid_q <= 1'b0;
            fill_alloc_q <= 1'b0;
            fill_way_q   <= '0;
            binv_valid_q <= 1'b0;
            binv_addr_q  <= '0;
            flash_q      <= 1'b0;
        end
        else if (ce)
        begin
            mask_q       <= mask_d;
            fill_valid_q <= fill_valid_d;
            fill_alloc_q <= fill_alloc_d;
            fill_way_q   <= fill_way_d;
            binv_valid_q <= binv_valid_d;
            binv_addr_q  <= binv_addr_d;
            flash_q      <= flash_d;
        end
    end

    assign lk.lock_mask     = mask_q;
    assign lk.fill_valid    = fill_valid_q;
    assign lk.fill_alloc    = fill_alloc_q;
    assign lk.fill_way      = fill_way_q;
    assign lk.binv_valid    = binv_valid_q;
    assign lk.binv_addr_out = binv_addr_q;
    assign lk.flash_inval   = flash_q;

    ////////////////////////////////////////////////////////////////////////
    whole_lock_all_a : assert property (ce && lk.enable // see R1
        && lk.whole_lock |=> &mask_q)
        else $error("whole lock did not lock every way");

    way_count_six_a : assert property (ce && lk.enable // see R4
        && !lk.whole_lock && lk.way_count == 3'h6
        |=> (&mask_q[5:0]) && !mask_q[6])
        else $error("count six did not lock ways 0 to 5");

    disabled_no_lock_a : assert property (ce && !lk.enable // see R7
        |=> mask_q == '0)
        else $error("lock applied to a disabled cache");

    sequence locked_miss_s;
        ce && lk.miss_req && lk.whole_lock;
    endsequence
    locked_miss_bypass_a : assert property (locked_miss_s // see R17
        |=> fill_valid_q && !fill_alloc_q)
        else $error("miss allocated in a locked cache");

    victim_unlocked_a : assert property (fill_valid_q // see R18
        && fill_alloc_q |-> !mask_q[fill_way_q])
        else $error("victim chosen in a locked way");

    block_inval_a : assert property (ce && lk.binv_req // see R10
        |=> binv_valid_q && binv_addr_q == $past(lk.binv_addr))
        else $error("block invalidate dropped");

    flash_any_lock_a : assert property (ce && lk.flash_req // see R9
        && lk.whole_lock |=> flash_q ##1 !flash_q || !ce)
        else $error("flash invalidate blocked by lock");
endmodule

// ---- design/cache_lock_control.sv ----
// Cache lock and invalidate control registers with both cache lock units
// Contract
// R1: Data whole-lock bit 19 set locks the entire data cache; clear unlocks.
// R2: Software issues a memory barrier before setting the data whole-lock bit.
// R3: Data way-lock count field sits in bits 24 to 26 of impl_config_b.
// R4: Data count N locks ways 0 to N-1; zero locks none.
// R5: Instruction way-lock count field sits in bits 16 to 18 of impl_config_b.
// R6: Instruction whole-lock bit 18 locks the entire instruction cache.
// R7: Locks act only while that cache's enable, bit 16 or 17, is set.
// R8: Writing one then zero to bit 20 or 21 flash-invalidates that cache.
// R9: Flash invalidation clears the whole cache whatever its locks.
// R10: Data block invalidate works on whole-locked or way-locked blocks.
// R11: Instruction block invalidate works on whole-locked or way-locked blocks.
// R12: Software keeps external interrupts and machine check off while loading.
// R13: Machine-state bits 26 and 27 enable instruction and data translation.
// R14: Instruction count N locks instruction ways 0 to N-1; zero none.
// R15: Instruction whole-lock locks all instruction ways regardless of count.
// R16: Software issues an instruction barrier before setting instruction lock.
// R17: Whole-locked cache serves hits; misses bypass without allocation.
// R18: Way locking restricts replacement to unlocked ways.
`timescale 1ns/100ps
module cache_lock_control
#(
    parameter int WAYS   = cache_lock_pkg::DEF_WAYS,
    parameter int ADDR_W = cache_lock_pkg::DEF_ADDR_W
)
(
    // Clock, reset, enable
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    // Special-purpose register port
    input  wire logic                        spr_wr,
    input  wire logic                        spr_rd,
    input  wire logic [1:0]                  spr_sel,
    input  wire logic [31:0]                 spr_wdata,
    output logic      [31:0]                 spr_rdata,
    output logic                             spr_rvalid,
    // Instruction cache side
    input  wire logic                        ic_miss,
    input  wire logic [$clog2(WAYS)-1:0]     ic_victim_hint,
    input  wire logic                        ic_binv_req,
    input  wire logic [ADDR_W-1:0]           ic_binv_addr,
    output logic      [WAYS-1:0]             ic_lock_mask,
    output logic                             ic_fill_valid,
    output logic                             ic_fill_alloc,
    output logic      [$clog2(WAYS)-1:0]     ic_fill_way,
    output logic                             ic_binv_valid,
    output logic      [ADDR_W-1:0]           ic_binv_addr_out,
    output logic                             ic_flash_inval,
    // Data cache side
    input  wire logic                        dc_miss,
    input  wire logic [$clog2(WAYS)-1:0]     dc_victim_hint,
    input  wire logic                        dc_binv_req,
    input  wire logic [ADDR_W-1:0]           dc_binv_addr,
    output logic      [WAYS-1:0]             dc_lock_mask,
    output logic                             dc_fill_valid,
    output logic                             dc_fill_alloc,
    output logic      [$clog2(WAYS)-1:0]     dc_fill_way,
    output logic                             dc_binv_valid,
    output logic      [ADDR_W-1:0]           dc_binv_addr_out,
    output logic                             dc_flash_inval,
    // Machine-state view
    output logic                             instr_translate_en,
    output logic                             data_translate_en,
    output logic                             ext_irq_enable,
    output logic                             machine_check_enable
);
    localparam int INSTR_CACHE_ENABLE  = cache_lock_pkg::lsb_index(
                              cache_lock_pkg::INSTR_CACHE_ENABLE_POS);
    localparam int DCE  = cache_lock_pkg::lsb_index(
                              cache_lock_pkg::DATA_CACHE_ENABLE_POS);
    localparam int ILK  = cache_lock_pkg::lsb_index(
                              cache_lock_pkg::INSTR_WHOLE_LOCK_POS);
    localparam int DLK  = cache_lock_pkg::lsb_index(
                              cache_lock_pkg::DATA_WHOLE_LOCK_POS);
    localparam int IFI  = cache_lock_pkg::lsb_index(
                              cache_lock_pkg::INSTR_FLASH_INVALIDATE_POS);
    localparam int DFI  = cache_lock_pkg::lsb_index(
                              cache_lock_pkg::DATA_FLASH_INVALIDATE_POS);
    localparam int IWAY = cache_lock_pkg::lsb_index(
                              cache_lock_pkg::INSTR_WAY_LOCK_FIRST);
    localparam int DWAY = cache_lock_pkg::lsb_index(
                              cache_lock_pkg::DATA_WAY_LOCK_FIRST);
    localparam int CW   = cache_lock_pkg::WAY_COUNT_W;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [31:0] cfg_a_d;
    logic [31:0] cfg_a_q;
    logic [31:0] cfg_b_d;
    logic [31:0] cfg_b_q;
    logic [31:0] mstate_d;
    logic [31:0] mstate_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        rvalid_d;
    logic        rvalid_q;
    logic        ifi_fire;
    logic        dfi_fire;
    cache_lock_pkg::spr_sel_type sel;

    assign sel = cache_lock_pkg::spr_sel_type'(spr_sel);

    always_comb
    begin
        cfg_a_d  = cfg_a_q;
        cfg_b_d  = cfg_b_q;
        mstate_d = mstate_q;
        ifi_fire = 1'b0;
        dfi_fire = 1'b0;
        if (spr_wr)
        begin
            unique case (sel)
                cache_lock_pkg::SEL_IMPL_CONFIG_A:
                begin
                    cfg_a_d  = spr_wdata;
                    // The clearing write of a one-then-zero toggle fires
                    ifi_fire = cfg_a_q[IFI] && !spr_wdata[IFI]; // see R8
                    dfi_fire = cfg_a_q[DFI] && !spr_wdata[DFI]; // see R8
                end
                cache_lock_pkg::SEL_IMPL_CONFIG_B: cfg_b_d  = spr_wdata;
                cache_lock_pkg::SEL_MACHINE_STATE: mstate_d = spr_wdata;
                cache_lock_pkg::SEL_UNMAPPED:      cfg_b_d  = cfg_b_q;
            endcase
        end
        rvalid_d = spr_rd;
        rdata_d  = rdata_q;
        if (spr_rd)
        begin
            unique case (sel)
                cache_lock_pkg::SEL_IMPL_CONFIG_A: rdata_d = cfg_a_q;
                cache_lock_pkg::SEL_IMPL_CONFIG_B: rdata_d = cfg_b_q;
                cache_lock_pkg::SEL_MACHINE_STATE: rdata_d = mstate_q;
                cache_lock_pkg::SEL_UNMAPPED:      rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            cfg_a_q  <= cache_lock_pkg::IMPL_CONFIG_A_RESET;
            cfg_b_q  <= cache_lock_pkg::IMPL_CONFIG_B_RESET;
            mstate_q <= cache_lock_pkg::MACHINE_STATE_RESET;
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end
        else if (ce)
        begin
            cfg_a_q  <= cfg_a_d;
            cfg_b_q  <= cfg_b_d;
            mstate_q <= mstate_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign spr_rdata  = rdata_q;
    assign spr_rvalid = rvalid_q;

    // Translation enables go straight to the memory management unit, see R13
    assign instr_translate_en = mstate_q[cache_lock_pkg::lsb_index(
                                    cache_lock_pkg::INSTR_TRANSLATE_EN_POS)];
    assign data_translate_en  = mstate_q[cache_lock_pkg::lsb_index(
                                    cache_lock_pkg::DATA_TRANSLATE_EN_POS)];
    assign ext_irq_enable       = mstate_q[cache_lock_pkg::lsb_index(
                                    cache_lock_pkg::EXT_IRQ_ENABLE_POS)];
    assign machine_check_enable = mstate_q[cache_lock_pkg::lsb_index(
                                    cache_lock_pkg::MACHINE_CHECK_ENABLE_POS)];

    ////////////////////////////////////////////////////////////////////////
    // Instruction cache lock unit
    cache_lock_if #(.WAYS(WAYS), .ADDR_W(ADDR_W)) ic_if ();

    assign ic_if.enable      = cfg_a_q[INSTR_CACHE_ENABLE];                   // see R7
    assign ic_if.whole_lock  = cfg_a_q[ILK];                   // see R6, R15
    assign ic_if.way_count   = cfg_b_q[IWAY -: CW];            // see R5
    assign ic_if.flash_req   = ifi_fire;
    assign ic_if.miss_req    = ic_miss;
    assign ic_if.victim_hint = ic_victim_hint;
    assign ic_if.binv_req    = ic_binv_req;                    // see R11
    assign ic_if.binv_addr   = ic_binv_addr;

    way_lock_unit #(.WAYS(WAYS), .ADDR_W(ADDR_W)) u_ic
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .lk      (ic_if.unit)
    );

    assign ic_lock_mask     = ic_if.lock_mask;
    assign ic_fill_valid    = ic_if.fill_valid;
    assign ic_fill_alloc    = ic_if.fill_alloc;
    assign ic_fill_way      = ic_if.fill_way;
    assign ic_binv_valid    = ic_if.binv_valid;
    assign ic_binv_addr_out = ic_if.binv_addr_out;
    assign ic_flash_inval   = ic_if.flash_inval;

    ////////////////////////////////////////////////////////////////////////
    // Data cache lock unit
    cache_lock_if #(.WAYS(WAYS), .ADDR_W(ADDR_W)) dc_if ();

    assign dc_if.enable      = cfg_a_q[DCE];                   // see R7
    assign dc_if.whole_lock  = cfg_a_q[DLK];                   // see R1
    assign dc_if.way_count   = cfg_b_q[DWAY -: CW];            // see R3
    assign dc_if.flash_req   = dfi_fire;
    assign dc_if.miss_req    = dc_miss;
    assign dc_if.victim_hint = dc_victim_hint;
    assign dc_if.binv_req    = dc_binv_req;                    // see R10
    assign dc_if.binv_addr   = dc_binv_addr;

    way_lock_unit #(.WAYS(WAYS), .ADDR_W(ADDR_W)) u_dc
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .lk      (dc_if.unit)
    );

    assign dc_lock_mask     = dc_if.lock_mask;
    assign dc_fill_valid    = dc_if.fill_valid;
    assign dc_fill_alloc    = dc_if.fill_alloc;
    assign dc_fill_way      = dc_if.fill_way;
    assign dc_binv_valid    = dc_if.binv_valid;
    assign dc_binv_addr_out = dc_if.binv_addr_out;
    assign dc_flash_inval   = dc_if.flash_inval;

    ////////////////////////////////////////////////////////////////////////
    sequence ifi_set_s;
        ce && spr_wr && sel == cache_lock_pkg::SEL_IMPL_CONFIG_A
        && spr_wdata[IFI];
    endsequence
    sequence ifi_clear_s;
        ce && spr_wr && sel == cache_lock_pkg::SEL_IMPL_CONFIG_A
        && cfg_a_q[IFI] && !spr_wdata[IFI];
    endsequence
    icache_flash_a : assert property (ifi_clear_s |=> ic_flash_inval) // see R8
        else $error("instruction flash toggle did not invalidate");

    // Only the clearing half of the toggle may fire
    iflash_set_a : assert property (ifi_set_s |=> !ic_flash_inval) // see R8
        else $error("setting the flash bit fired early");

    dway_field_a : assert property (ce && spr_wr // see R3
        && sel == cache_lock_pkg::SEL_IMPL_CONFIG_B
        |=> dc_if.way_count == $past(spr_wdata[7:5]))
        else $error("data way count not taken from bits 24 to 26");

    iway_field_a : assert property (ce && spr_wr // see R5
        && sel == cache_lock_pkg::SEL_IMPL_CONFIG_B
        |=> ic_if.way_count == $past(spr_wdata[15:13]))
        else $error("instruction way count not taken from bits 16 to 18");

    instr_whole_lock_all_a : assert property (cfg_a_q[INSTR_CACHE_ENABLE] && cfg_a_q[ILK] // see R15
        && ce |=> &ic_lock_mask)
        else $error("instruction whole lock left a way open");

    itrans_en_a : assert property (ce && spr_wr // see R13
        && sel == cache_lock_pkg::SEL_MACHINE_STATE
        |=> instr_translate_en == $past(spr_wdata[5])
            && data_translate_en == $past(spr_wdata[4]))
        else $error("translation enables not taken from bits 26 and 27");
endmodule

// ---- verification/test_cache_lock_control.sv ----
// Self-checking bench for the cache lock control block
`timescale 1ns/100ps
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %0t %s", $time, m); end end
module test_cache_lock_control;
    localparam logic [1:0]  SA   = cache_lock_pkg::SEL_IMPL_CONFIG_A;
    localparam logic [1:0]  SB   = cache_lock_pkg::SEL_IMPL_CONFIG_B;
    localparam logic [1:0]  SM   = cache_lock_pkg::SEL_MACHINE_STATE;
    localparam logic [1:0]  SU   = cache_lock_pkg::SEL_UNMAPPED;
    // Big-endian bit n sits at vector index 31-n
    localparam logic [31:0] INSTR_CACHE_ENABLE  = 32'h0000_8000;
    localparam logic [31:0] DCE  = 32'h0000_4000;
    localparam logic [31:0] ILK  = 32'h0000_2000;
    localparam logic [31:0] DLK  = 32'h0000_1000;
    localparam logic [31:0] INSTR_FLASH_INVALIDATE = 32'h0000_0800;
    localparam logic [31:0] DATA_FLASH_INVALIDATE = 32'h0000_0400;
    localparam logic [31:0] EE   = 32'h0000_8000;
    localparam logic [31:0] ME   = 32'h0000_1000;
    localparam logic [31:0] IR   = 32'h0000_0020;
    localparam logic [31:0] DR   = 32'h0000_0010;
    logic        clk_sys = 0, rstn = 0, ce = 1, spr_wr = 0, spr_rd = 0;
    logic        ic_miss = 0, dc_miss = 0, ic_binv_req = 0, dc_binv_req = 0;
    logic [1:0]  spr_sel = 0;
    logic [2:0]  ic_victim_hint = 0, dc_victim_hint = 0;
    logic [2:0]  ic_fill_way, dc_fill_way;
    logic [31:0] spr_wdata = 0, ic_binv_addr = 0, dc_binv_addr = 0;
    logic [31:0] spr_rdata, ic_binv_addr_out, dc_binv_addr_out;
    logic [7:0]  ic_lock_mask, dc_lock_mask;
    logic        spr_rvalid, ic_fill_valid, ic_fill_alloc, ic_binv_valid;
    logic        ic_flash_inval, dc_fill_valid, dc_fill_alloc, dc_binv_valid;
    logic        dc_flash_inval, instr_translate_en, data_translate_en;
    logic        ext_irq_enable, machine_check_enable;
    int          n_mismatch = 0, num_checks = 0;

    cache_lock_control #(.WAYS(8), .ADDR_W(32)) dut
    (
        .clk_sys, .rstn, .ce, .spr_wr, .spr_rd, .spr_sel, .spr_wdata,
        .spr_rdata, .spr_rvalid, .ic_miss, .ic_victim_hint, .ic_binv_req,
        .ic_binv_addr, .ic_lock_mask, .ic_fill_valid, .ic_fill_alloc,
        .ic_fill_way, .ic_binv_valid, .ic_binv_addr_out, .ic_flash_inval,
        .dc_miss, .dc_victim_hint, .dc_binv_req, .dc_binv_addr,
        .dc_lock_mask, .dc_fill_valid, .dc_fill_alloc, .dc_fill_way,
        .dc_binv_valid, .dc_binv_addr_out, .dc_flash_inval,
        .instr_translate_en, .data_translate_en, .ext_irq_enable,
        .machine_check_enable
    );

    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lm(input int n);
        return 8'((1 << n) - 1);
    endfunction

    // Extra idle cycle at the end lets the lock masks follow the write
    task automatic wr(input logic [1:0] s, input logic [31:0] d);
        @(negedge clk_sys);
        spr_wr = 1; spr_sel = s; spr_wdata = d;
        @(negedge clk_sys);
        spr_wr = 0;
        @(negedge clk_sys);
    endtask

    task automatic rd(input logic [1:0] s, input logic [31:0] e);
        @(negedge clk_sys);
        spr_rd = 1; spr_sel = s;
        @(negedge clk_sys);
        spr_rd = 0;
        `CHK(spr_rvalid, 1'b1, "read valid")
        `CHK(spr_rdata, e, "read data")
    endtask

    task automatic miss(input bit d, input logic [2:0] h, input logic ea,
                        input logic [2:0] ew);
        @(negedge clk_sys);
        dc_miss = d; ic_miss = !d; dc_victim_hint = h; ic_victim_hint = h;
        @(negedge clk_sys);
        dc_miss = 0; ic_miss = 0;
        `CHK(d ? dc_fill_valid : ic_fill_valid, 1'b1, "fill valid")
        `CHK(d ? dc_fill_alloc : ic_fill_alloc, ea, "fill alloc")
        if (ea) `CHK(d ? dc_fill_way : ic_fill_way, ew, "fill way")
    endtask

    task automatic binv(input bit d, input logic [31:0] a);
        @(negedge clk_sys);
        dc_binv_req = d; ic_binv_req = !d; dc_binv_addr = a; ic_binv_addr = a;
        @(negedge clk_sys);
        dc_binv_req = 0; ic_binv_req = 0;
        `CHK(d ? dc_binv_valid : ic_binv_valid, 1'b1, "block inval")
        `CHK(d ? dc_binv_addr_out : ic_binv_addr_out, a, "block addr")
    endtask

    // Pulses are counted over a span wide enough for either latency reading
    task automatic flash(input logic [31:0] base, input bit d);
        int ni, nd;
        ni = 0; nd = 0;
        wr(SA, base | (d ? DATA_FLASH_INVALIDATE : INSTR_FLASH_INVALIDATE));
        @(negedge clk_sys);
        spr_wr = 1; spr_wdata = base;
        repeat (5)
        begin
            @(negedge clk_sys);
            spr_wr = 0; ni += (ic_flash_inval === 1'b1); nd += (dc_flash_inval === 1'b1);
        end
        `CHK(ni, d ? 0 : 1, "instr flash count")
        `CHK(nd, d ? 1 : 0, "data flash count")
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_ways;
        wr(SA, INSTR_CACHE_ENABLE | DCE);
        for (int n = 0; n < 8; n++)
        begin
            wr(SB, (32'(n) << 13) | (32'(7 - n) << 5));
            rd(SB, (32'(n) << 13) | (32'(7 - n) << 5));
            `CHK(ic_lock_mask, lm(n), "instr way mask")
            `CHK(dc_lock_mask, lm(7 - n), "data way mask")
            miss(0, 3'h0, 1'b1, 3'(n));
            miss(1, 3'h0, 1'b1, 3'(7 - n));
            miss(0, 3'h7, 1'b1, 3'h7);
        end
        $display("way lock test done");
    endtask

    task automatic t_whole;
        wr(SB, (32'h0000_0002 << 13) | (32'h0000_0003 << 5));
        wr(SA, INSTR_CACHE_ENABLE | DCE | DLK);
        `CHK(dc_lock_mask, 8'hff, "data whole mask")
        `CHK(ic_lock_mask, lm(2), "instr mask kept")
        miss(1, 3'h5, 1'b0, 3'h0);
        miss(0, 3'h0, 1'b1, 3'h2);
        binv(1, 32'h0000_1240);
        wr(SA, INSTR_CACHE_ENABLE | DCE | DLK | ILK);
        `CHK(ic_lock_mask, 8'hff, "instr whole mask")
        miss(0, 3'h4, 1'b0, 3'h0);
        binv(0, 32'h0000_a5e0);
        wr(SA, INSTR_CACHE_ENABLE | DCE);
        `CHK(dc_lock_mask, lm(3), "data unlocked")
        miss(1, 3'h0, 1'b1, 3'h3);
        wr(SA, ILK | DLK);
        `CHK(ic_lock_mask, 8'h00, "instr disabled")
        `CHK(dc_lock_mask, 8'h00, "data disabled")
        miss(0, 3'h1, 1'b0, 3'h0);
        miss(1, 3'h1, 1'b0, 3'h0);
        $display("whole lock test done");
    endtask

    task automatic t_regs;
        rd(SA, ILK | DLK);
        rd(SM, 32'h0000_0000);
        rd(SU, 32'h0000_0000);
        flash(INSTR_CACHE_ENABLE | DCE | ILK | DLK, 0);
        flash(INSTR_CACHE_ENABLE | DCE | ILK | DLK, 1);
        wr(SM, EE | ME);
        `CHK({ext_irq_enable, machine_check_enable}, 2'b11, "irq bits")
        `CHK({instr_translate_en, data_translate_en}, 2'b00, "xlat off")
        wr(SM, IR | DR);
        `CHK({instr_translate_en, data_translate_en}, 2'b11, "xlat on")
        `CHK({ext_irq_enable, machine_check_enable}, 2'b00, "irq off")
        wr(SU, 32'hffff_ffff);
        ce = 0;
        wr(SM, EE);
        ce = 1;
        rd(SM, IR | DR);
        rd(SU, 32'h0000_0000);
        $display("register and flash test done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(negedge clk_sys);
        rstn = 1;
        rd(SB, 32'h0000_0000);
        t_ways;
        t_whole;
        t_regs;
        wrap_up;
    end

    initial
    begin
        #100000;
        n_mismatch++;
        wrap_up;
    end
endmodule
